// >>> include/rwc_pkg.sv
// constants, field layouts and types shared by the reset and watchdog block
// assumes a 40 MHz system clock and a separate ultra-low-power oscillator pin
package rwc_pkg;
    localparam int CLOCK_PERIOD_NS = 25;

    // start-up stretch times in ns, one per start-up delay fuse code
    localparam int STRETCH_NS_0 = 1600;
    localparam int STRETCH_NS_1 = 6400;
    localparam int STRETCH_NS_2 = 25600;
    localparam int STRETCH_NS_3 = 102400;
    localparam int STRETCH_W = 13;
    localparam logic [12:0] STRETCH_CYC_0 = 13'((STRETCH_NS_0 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [12:0] STRETCH_CYC_1 = 13'((STRETCH_NS_1 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [12:0] STRETCH_CYC_2 = 13'((STRETCH_NS_2 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [12:0] STRETCH_CYC_3 = 13'((STRETCH_NS_3 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // reset cause register bit positions and reset value
    localparam int CAUSE_W = 5;
    localparam int POWER_BIT = 0;
    localparam int EXT_BIT = 1;
    localparam int UNDERV_BIT = 2;
    localparam int DOG_BIT = 3;
    localparam int DEBUG_BIT = 4;
    localparam logic [4:0] CAUSE_RESET = 5'h01;

    // synchronised pin vector layout and its reset value
    localparam int PIN_W = 8;
    localparam int PIN_POWER_LOW = 0;
    localparam int PIN_RESET_N = 1;
    localparam int PIN_BELOW = 2;
    localparam int PIN_ULP = 3;
    localparam int PIN_UV_FUSE = 4;
    localparam int PIN_FORCED_FUSE = 5;
    localparam int PIN_SUT_LO = 6;
    localparam logic [7:0] PIN_RESET = 8'h02;

    // timed unlock windows, in system clocks
    localparam logic [2:0] WINDOW_LOAD = 3'h4;

    // watchdog expiry: 2K oscillator cycles doubled per select step
    localparam int DOG_CNT_W = 21;
    localparam logic [20:0] DOG_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam logic [3:0] SEL_RESET = 4'h0;

    typedef enum logic [1:0] {
        RWC_HOLD = 2'h0,
        RWC_COUNT = 2'h1,
        RWC_RUN = 2'h3
    } rwc_stretch_type;

    typedef struct packed {
        logic timeout_irq_flag;
        logic timeout_irq_enable;
        logic config_change_unlock;
        logic dog_reset_enable;
        logic [3:0] timeout_select;
    } rwc_guard_ctrl_type;

    typedef struct packed {
        logic lock_arm_bit;
        logic config_lock_bit;
    } rwc_lock_type;
endpackage

// >>> src/rwc_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous levels; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rwc_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // per bit, a change is taken only when stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync_out <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    sync_out[i] <= stage3_reg[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/rwc_top.sv
// reset combiner with start-up stretch, reset cause flags and watchdog
// assumes the core gives one-cycle write strobes and a restart pulse on clock
`timescale 1ns/1ps
`default_nettype none
module rwc_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // reset sources, fuses and the low-power oscillator
    input wire logic power_low,
    input wire logic reset_pin_n,
    input wire logic below_trigger,
    input wire logic debug_reset_req,
    input wire logic undervoltage_fuse,
    input wire logic forced_on_fuse,
    input wire logic [1:0] startup_delay_fuse,
    input wire logic ulp_osc,
    // core side
    input wire logic restart_pulse,
    input wire logic irq_ack,
    input wire logic guard_wr_en,
    input wire rwc_pkg::rwc_guard_ctrl_type guard_wr_data,
    input wire logic lock_wr_en,
    input wire rwc_pkg::rwc_lock_type lock_wr_data,
    input wire logic cause_wr_en,
    input wire logic [rwc_pkg::CAUSE_W-1:0] cause_wr_data,
    // results
    output logic internal_reset,
    output rwc_pkg::rwc_guard_ctrl_type guard_status,
    output rwc_pkg::rwc_lock_type lock_status,
    output logic [rwc_pkg::CAUSE_W-1:0] reset_cause_register,
    output logic timeout_irq
);
    import rwc_pkg::*;
    logic [PIN_W-1:0] pin_s;
    logic power_s, pin_low_s, under_s, forced_s, ulp_prev_reg, ulp_tick, async_src, sources_active;
    rwc_stretch_type stretch_reg, stretch_next;
    logic [STRETCH_W-1:0] stretch_cnt_reg, stretch_limit;
    logic reset_out_reg, dog_pulse_reg, irq_flag_reg, irq_en_reg, rst_en_reg, locked_reg;
    logic [CAUSE_W-1:0] cause_reg, cause_set;
    logic [3:0] sel_reg, sel_eff;
    logic [2:0] unlock_cnt_reg, arm_cnt_reg;
    logic [DOG_CNT_W-1:0] dog_cnt_reg, dog_limit;
    logic dog_flag, rst_en_eff, irq_en_eff, dog_enabled, expire, unlock_write, change_ok, guard_clear;

    rwc_sync3 #(
        .WIDTH(PIN_W),
        .RESET_VAL(PIN_RESET)
    ) u_pins (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({startup_delay_fuse, forced_on_fuse, undervoltage_fuse, ulp_osc,
                   below_trigger, reset_pin_n, power_low}),
        .sync_out(pin_s)
    );

    assign power_s = pin_s[PIN_POWER_LOW];
    assign pin_low_s = ~pin_s[PIN_RESET_N];
    assign under_s = pin_s[PIN_UV_FUSE] & pin_s[PIN_BELOW];
    assign forced_s = pin_s[PIN_FORCED_FUSE];
    assign ulp_tick = pin_s[PIN_ULP] & ~ulp_prev_reg;

    // raw levels, so the port reset needs no clock
    assign async_src = power_low | ~reset_pin_n | (undervoltage_fuse & below_trigger);
    assign sources_active = power_s | pin_low_s | under_s | debug_reset_req | dog_pulse_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ulp_prev_reg <= 1'b0;
        end else begin
            ulp_prev_reg <= pin_s[PIN_ULP];
        end
    end

    // stretch length from start-up delay fuse
    always_comb begin
        unique case (pin_s[PIN_SUT_LO +: 2])
            2'h0: stretch_limit = STRETCH_CYC_0;
            2'h1: stretch_limit = STRETCH_CYC_1;
            2'h2: stretch_limit = STRETCH_CYC_2;
            2'h3: stretch_limit = STRETCH_CYC_3;
        endcase
    end

    // release only after the stretch count
    always_comb begin
        stretch_next = stretch_reg;
        if (sources_active) begin
            stretch_next = RWC_HOLD;
        end else begin
            unique case (stretch_reg)
                RWC_HOLD: stretch_next = RWC_COUNT;
                RWC_COUNT: begin
                    if (stretch_cnt_reg == stretch_limit - 13'h0001) begin
                        stretch_next = RWC_RUN;
                    end
                end
                RWC_RUN: stretch_next = RWC_RUN;
                default: stretch_next = RWC_HOLD;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stretch_reg <= RWC_HOLD;
        end else begin
            stretch_reg <= stretch_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || stretch_reg != RWC_COUNT) begin
            stretch_cnt_reg <= '0;
        end else begin
            stretch_cnt_reg <= stretch_cnt_reg + 13'h0001;
        end
    end

    // asynchronous set, synchronous release through the stretch
    always_ff @(posedge clock or posedge async_src) begin
        if (async_src) begin
            reset_out_reg <= 1'b1;
        end else if (!rst_n) begin
            reset_out_reg <= 1'b1;
        end else begin
            reset_out_reg <= (stretch_next != RWC_RUN);
        end
    end
    // the same level clears the core's registers and sends it to its vector
    assign internal_reset = reset_out_reg;

    // per-cause flags; a set wins over a software clear
    always_comb begin
        cause_set = '0;
        cause_set[EXT_BIT] = pin_low_s;
        cause_set[UNDERV_BIT] = under_s;
        cause_set[DOG_BIT] = dog_pulse_reg;
        cause_set[DEBUG_BIT] = debug_reset_req;
    end

    always_ff @(posedge clock) begin
        if (!rst_n || power_s) begin
            cause_reg <= CAUSE_RESET;
        end else if (cause_wr_en) begin
            cause_reg <= (cause_reg & cause_wr_data) | cause_set;
        end else begin
            cause_reg <= cause_reg | cause_set;
        end
    end

    assign dog_flag = cause_reg[DOG_BIT];
    // forced fuse pins the mode to reset-only
    assign rst_en_eff = forced_s | rst_en_reg | dog_flag;
    assign irq_en_eff = ~forced_s & irq_en_reg;
    assign dog_enabled = rst_en_eff | irq_en_eff;
    assign guard_clear = !rst_n || reset_out_reg;

    // reserved codes behave as the longest period
    assign sel_eff = (sel_reg > SEL_MAX) ? SEL_MAX : sel_reg;
    assign dog_limit = DOG_BASE_CYCLES << sel_eff;
    // expiry on the tick that reaches the limit
    assign expire = dog_enabled && ulp_tick && (dog_cnt_reg == dog_limit - 21'h000001);

    always_ff @(posedge clock) begin
        if (guard_clear || restart_pulse || expire || !dog_enabled) begin
            dog_cnt_reg <= '0;
        end else if (ulp_tick) begin
            dog_cnt_reg <= dog_cnt_reg + 21'h000001;
        end
    end

    // one clock of reset on expiry in reset-only mode
    always_ff @(posedge clock) begin
        if (guard_clear) begin
            dog_pulse_reg <= 1'b0;
        end else begin
            dog_pulse_reg <= expire && rst_en_eff && !irq_en_eff;
        end
    end

    // unlock only with reset-enable written as one
    assign unlock_write = guard_wr_en && guard_wr_data.config_change_unlock
                          && guard_wr_data.dog_reset_enable && !locked_reg;
    // a change is taken only inside the window
    assign change_ok = guard_wr_en && !guard_wr_data.config_change_unlock
                       && (unlock_cnt_reg != 3'h0) && !locked_reg;

    always_ff @(posedge clock) begin
        if (guard_clear) begin
            unlock_cnt_reg <= 3'h0;
        end else if (unlock_write) begin
            unlock_cnt_reg <= WINDOW_LOAD;
        end else if (change_ok) begin
            unlock_cnt_reg <= 3'h0;
        end else if (unlock_cnt_reg != 3'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        end
    end

    // interrupt flag; expiry wins over acknowledge or write-one clear
    always_ff @(posedge clock) begin
        if (guard_clear) begin
            irq_flag_reg <= 1'b0;
        end else if (expire && irq_en_eff) begin
            irq_flag_reg <= 1'b1;
        end else if (irq_ack || (guard_wr_en && guard_wr_data.timeout_irq_flag)) begin
            irq_flag_reg <= 1'b0;
        end
    end

    // first expiry in combined mode drops to reset-only
    always_ff @(posedge clock) begin
        if (guard_clear) begin
            irq_en_reg <= 1'b0;
        end else if (expire && irq_en_eff && rst_en_eff) begin
            irq_en_reg <= 1'b0;
        end else if (guard_wr_en && !locked_reg) begin
            irq_en_reg <= guard_wr_data.timeout_irq_enable;
        end
    end

    // clearing reset-enable needs the window and a clear cause flag
    always_ff @(posedge clock) begin
        if (guard_clear) begin
            rst_en_reg <= 1'b0;
            sel_reg <= SEL_RESET;
        end else if (change_ok) begin
            rst_en_reg <= guard_wr_data.dog_reset_enable | dog_flag;
            sel_reg <= guard_wr_data.timeout_select;
        end else if (guard_wr_en && guard_wr_data.dog_reset_enable && !locked_reg) begin
            rst_en_reg <= 1'b1;
        end
    end

    // arm then confirm within four clocks; held until reset
    always_ff @(posedge clock) begin
        if (guard_clear) begin
            arm_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
        end else if (lock_wr_en && lock_wr_data.lock_arm_bit && lock_wr_data.config_lock_bit) begin
            arm_cnt_reg <= WINDOW_LOAD;
        end else if (lock_wr_en && !lock_wr_data.lock_arm_bit && lock_wr_data.config_lock_bit
                     && arm_cnt_reg != 3'h0) begin
            arm_cnt_reg <= 3'h0;
            locked_reg <= 1'b1;
        end else if (arm_cnt_reg != 3'h0) begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
        end
    end

    // status copies are registered so every output leaves a flip-flop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            guard_status <= '0;
            lock_status <= '0;
            reset_cause_register <= CAUSE_RESET;
            timeout_irq <= 1'b0;
        end else begin
            guard_status.timeout_irq_flag <= irq_flag_reg;
            guard_status.timeout_irq_enable <= irq_en_eff;
            guard_status.config_change_unlock <= (unlock_cnt_reg != 3'h0);
            guard_status.dog_reset_enable <= rst_en_eff;
            guard_status.timeout_select <= sel_reg;
            lock_status.lock_arm_bit <= (arm_cnt_reg != 3'h0);
            lock_status.config_lock_bit <= locked_reg;
            reset_cause_register <= cause_reg;
            timeout_irq <= irq_flag_reg;
        end
    end

    dog_pulse_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        dog_pulse_reg |=> !dog_pulse_reg && reset_out_reg)
        else $error("watchdog reset pulse not one cycle or no reset");
    // the edge that ends the count drops the reset, so the check is on the same cycle
    stretch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (stretch_reg == RWC_COUNT) |-> reset_out_reg)
        else $error("internal reset released during stretch");
    source_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        sources_active |=> reset_out_reg ##1 (stretch_reg == RWC_HOLD || stretch_reg == RWC_COUNT))
        else $error("active source did not hold reset");
    forced_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
        forced_s && $past(forced_s) |-> guard_status.dog_reset_enable && !guard_status.timeout_irq_enable)
        else $error("forced fuse mode not applied");
    window_only_a: assert property (@(posedge clock) disable iff (!rst_n)
        !reset_out_reg && (unlock_cnt_reg == 3'h0) |=> sel_reg == $past(sel_reg))
        else $error("timeout select changed outside window");
    lock_held_a: assert property (@(posedge clock) disable iff (!rst_n)
        locked_reg && !reset_out_reg |=> locked_reg && $stable(sel_reg))
        else $error("configuration lock dropped or bypassed");
    restart_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        restart_pulse |=> dog_cnt_reg == '0)
        else $error("restart did not clear watchdog counter");
    irq_only_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && irq_en_eff && !rst_en_eff && !reset_out_reg |=> irq_flag_reg && !dog_pulse_reg ##1 timeout_irq)
        else $error("interrupt mode expiry misbehaved");
    combined_a: assert property (@(posedge clock) disable iff (!rst_n)
        expire && irq_en_eff && rst_en_eff && !reset_out_reg |=> !irq_en_reg && irq_flag_reg && !dog_pulse_reg)
        else $error("combined mode did not drop to reset mode");
    power_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        power_s |=> cause_reg == CAUSE_RESET)
        else $error("power-up did not clear other cause flags");
    dog_flag_en_a: assert property (@(posedge clock) disable iff (!rst_n)
        dog_flag && $past(dog_flag) |-> guard_status.dog_reset_enable)
        else $error("reset-enable not forced by watchdog cause");
endmodule
`default_nettype wire

// >>> tb/rwc_core_model.sv
// core stand-in: issues watchdog restarts and takes the watchdog interrupt
// assumes the bench steers kick; outputs change after the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module rwc_core_model (
    // clock and system reset
    input wire logic clock,
    input wire logic internal_reset,
    // watchdog side
    input wire logic kick,
    input wire logic timeout_irq,
    output logic restart_pulse,
    output logic irq_ack
);
    int gap = 0;
    always @(negedge clock) begin
        gap = (gap + 1) % 600;
        restart_pulse <= kick && gap == 0 && !internal_reset;
    end
    initial begin
        irq_ack = 1'b0;
        forever begin
            @(negedge clock);
            if (timeout_irq === 1'b1 && internal_reset === 1'b0) begin
                repeat (3) @(negedge clock);
                irq_ack <= 1'b1;
                @(negedge clock);
                irq_ack <= 1'b0;
                wait (timeout_irq !== 1'b1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the reset and watchdog block
// assumes the core model beside it; all inputs move on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
    import rwc_pkg::*;
    typedef struct {int id; logic [7:0] exp; logic [7:0] val;} rwc_note_type;
    logic clock = 1'b0, rst_n = 1'b0, power_low = 1'b0, reset_pin_n = 1'b1, below_trigger = 1'b0;
    logic debug_reset_req = 1'b0, undervoltage_fuse = 1'b0, forced_on_fuse = 1'b0, ulp_osc = 1'b0;
    logic restart_pulse, irq_ack, kick = 1'b1, internal_reset, timeout_irq;
    logic guard_wr_en = 1'b0, lock_wr_en = 1'b0, cause_wr_en = 1'b0;
    logic [1:0] startup_delay_fuse = 2'h0;
    logic [4:0] cause_wr_data = 5'h1F, reset_cause_register;
    rwc_guard_ctrl_type guard_wr_data = '0, guard_status;
    rwc_lock_type lock_wr_data = '0, lock_status;
    rwc_note_type q[$];
    rwc_note_type nt;
    string nm[6] = '{"internal_reset", "guard_status", "lock_status", "reset_cause", "timeout_irq", "timing"};
    logic [7:0] got;
    logic [31:0] seed = 32'h52;
    logic [3:0] sel;
    int bad_count = 0, samples_checked = 0, n, osc_div = 0;
    event look;

    rwc_top i_dut (.clock, .rst_n, .power_low, .reset_pin_n, .below_trigger, .debug_reset_req,
        .undervoltage_fuse, .forced_on_fuse, .startup_delay_fuse, .ulp_osc, .restart_pulse, .irq_ack,
        .guard_wr_en, .guard_wr_data, .lock_wr_en, .lock_wr_data, .cause_wr_en, .cause_wr_data,
        .internal_reset, .guard_status, .lock_status, .reset_cause_register, .timeout_irq);
    rwc_core_model i_core (.clock, .internal_reset, .kick, .timeout_irq, .restart_pulse, .irq_ack);

    initial forever #12.5 clock = ~clock;
    // oscillator at one sixth of the system clock keeps expiry runs short
    always @(negedge clock) begin
        osc_div = (osc_div + 1) % 3;
        if (osc_div == 0) ulp_osc <= ~ulp_osc;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic note(input int id, input logic [7:0] e, input logic [7:0] v = 8'h00);
        q.push_back('{id, e, v});
        -> look;
        #1;
    endtask
    task automatic in_range(input int lo, input int hi);
        note(5, 8'h01, {7'h00, (n >= lo && n <= hi)});
    endtask
    task automatic wait_sig(input bit irq, input logic v, input int lim);
        n = 0;
        while (((irq ? timeout_irq : internal_reset) !== v) && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic gwr(input logic [7:0] a, input logic [7:0] b, input bit two);
        guard_wr_data = a;
        guard_wr_en = 1'b1;
        tick(1);
        if (two) begin
            guard_wr_data = b;
            tick(1);
        end
        guard_wr_en = 1'b0;
    endtask
    task automatic clr_cause();
        cause_wr_data = 5'h00;
        cause_wr_en = 1'b1;
        tick(1);
        cause_wr_en = 1'b0;
        cause_wr_data = 5'h1F;
        tick(1);
    endtask
    // asserts one source, then times the stretched release
    task automatic src(ref logic s, input logic act, input bit async, input int hold, input int lo, input int hi);
        s = act;
        #1;
        if (async) note(0, 8'h01);
        tick(hold);
        s = ~act;
        tick(1);
        note(0, 8'h01);
        wait_sig(0, 1'b0, 5000);
        in_range(lo, hi);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always begin
        @(look);
        while (q.size() > 0) begin
            nt = q.pop_front();
            case (nt.id)
                0: got = {7'h00, internal_reset};
                1: got = guard_status;
                2: got = {6'h00, lock_status};
                3: got = {3'h0, reset_cause_register};
                4: got = {7'h00, timeout_irq};
                default: got = nt.val;
            endcase
            `CHK(nm[nt.id], nt.exp, got)
        end
    end

    initial begin
        #(90000 * 25);
        bad_count++;
        results();
    end

    initial begin
        tick(5);
        note(0, 8'h01);
        note(3, 8'h01);
        rst_n = 1'b1;
        wait_sig(0, 1'b0, 200);
        in_range(64, 80);
        note(1, 8'h00);
        note(2, 8'h00);
        clr_cause();
        note(3, 8'h00);
        startup_delay_fuse = 2'h1;
        tick(6);
        src(reset_pin_n, 1'b0, 1'b1, 10, 254, 266);
        note(3, 8'h02);
        clr_cause();
        startup_delay_fuse = 2'h0;
        below_trigger = 1'b1;
        tick(10);
        note(0, 8'h00);
        below_trigger = 1'b0;
        undervoltage_fuse = 1'b1;
        tick(6);
        src(below_trigger, 1'b1, 1'b1, 10, 62, 72);
        note(3, 8'h04);
        clr_cause();
        src(debug_reset_req, 1'b1, 1'b0, 1, 62, 70);
        note(3, 8'h10);
        src(power_low, 1'b1, 1'b1, 10, 62, 72);
        note(3, 8'h01);
        clr_cause();
        sel = 4'(rnd() % 15) + 4'h1;
        gwr(8'h30, {4'h0, sel}, 1'b1);
        tick(3);
        note(1, {4'h0, sel});
        gwr(8'h30, 8'h00, 1'b0);
        tick(6);
        gwr(8'h03, 8'h00, 1'b0);
        tick(3);
        note(1, {4'h1, sel});
        gwr(8'h30, 8'h40, 1'b1);
        tick(3);
        note(1, 8'h40);
        kick = 1'b0;
        wait_sig(1, 1'b1, 14000);
        in_range(11600, 12350);
        note(0, 8'h00);
        kick = 1'b1;
        tick(10);
        note(4, 8'h00);
        gwr(8'h30, 8'h50, 1'b1);
        wait_sig(1, 1'b1, 15000);
        in_range(15000, 15000);
        kick = 1'b0;
        wait_sig(1, 1'b1, 14000);
        note(4, 8'h01);
        tick(10);
        note(1, 8'h10);
        wait_sig(0, 1'b1, 14000);
        in_range(11000, 12350);
        wait_sig(0, 1'b0, 200);
        in_range(62, 72);
        kick = 1'b1;
        note(3, 8'h08);
        note(1, 8'h10);
        gwr(8'h30, 8'h00, 1'b1);
        tick(3);
        note(1, 8'h10);
        clr_cause();
        gwr(8'h30, 8'h00, 1'b1);
        tick(3);
        note(1, 8'h00);
        lock_wr_data = 2'h3;
        lock_wr_en = 1'b1;
        tick(1);
        lock_wr_data = 2'h1;
        tick(1);
        note(2, 8'h02);
        lock_wr_en = 1'b0;
        tick(3);
        note(2, 8'h01);
        gwr(8'h30, 8'h49, 1'b1);
        tick(3);
        note(1, 8'h00);
        src(debug_reset_req, 1'b1, 1'b0, 1, 62, 70);
        note(2, 8'h00);
        forced_on_fuse = 1'b1;
        tick(8);
        note(1, 8'h10);
        gwr(8'h40, 8'h00, 1'b0);
        tick(3);
        note(1, 8'h10);
        results();
    end
endmodule
`default_nettype wire
